// ==== rtl/jdi_pkg.sv ====
// Purpose: shared constants and types of the serial debug port
// Assumes: CPU side on a 100 MHz clock, test clock on its own domain
// Notes:   offsets are the byte addresses of control register space
package jdi_pkg;

  // ----------------------------------------------------------------
  // register map of the CPU side
  // ----------------------------------------------------------------
  localparam logic [31:0] DEBUG_COMMAND_REG_ADDR = 32'hFFF00000;
  localparam logic [31:0] DEBUG_DATA_HIGH_ADDR   = 32'hFFF00008;
  localparam logic [31:0] DEBUG_DATA_LOW_ADDR    = 32'hFFF0000A;
  localparam logic [31:0] DEBUG_IRQ_SOURCE_ADDR  = 32'hFFF00014;

  // ----------------------------------------------------------------
  // reset and fixed values
  // ----------------------------------------------------------------
  localparam logic [15:0] COMMAND_RESET     = 16'hFFFF;
  localparam logic [31:0] COMMAND_SERIAL_RD = 32'h0FFFFFFD;
  localparam logic [15:0] IRQ_SOURCE_RESET  = 16'h0000;
  localparam logic [7:0]  CMD_LOW_FILL      = 8'hFF;
  localparam int          IRQ_FLAG_BIT      = 0;

  // ----------------------------------------------------------------
  // command encodings, upper byte of the command register
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_BYPASS       = 8'hFF;
  localparam logic [3:0] CMD_RESET_NEGATE = 4'h6;
  localparam logic [3:0] CMD_RESET_ASSERT = 4'h7;
  localparam logic [2:0] CMD_INTERRUPT    = 3'h5;

  // ----------------------------------------------------------------
  // test access port states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET      = 4'h0,
    TAP_IDLE       = 4'h1,
    TAP_SEL_DR     = 4'h3,
    TAP_CAPTURE_DR = 4'h2,
    TAP_SHIFT_DR   = 4'h6,
    TAP_EXIT1_DR   = 4'h7,
    TAP_PAUSE_DR   = 4'h5,
    TAP_EXIT2_DR   = 4'h4,
    TAP_UPDATE_DR  = 4'hC,
    TAP_SEL_IR     = 4'hD,
    TAP_CAPTURE_IR = 4'hF,
    TAP_SHIFT_IR   = 4'hE,
    TAP_EXIT1_IR   = 4'hA,
    TAP_PAUSE_IR   = 4'hB,
    TAP_EXIT2_IR   = 4'h9,
    TAP_UPDATE_IR  = 4'h8
  } jdi_tap_type;

  // ----------------------------------------------------------------
  // signals carried from the test clock domain to the CPU domain
  // ----------------------------------------------------------------
  typedef struct packed {
    logic updToggle;
    logic irqToggle;
    logic inReset;
    logic resetAssert;
  } jdi_cross_type;

  // ----------------------------------------------------------------
  // CPU register access request
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        size32;
    logic [31:0] addr;
    logic [31:0] wdata;
  } jdi_cpu_req_type;

endpackage

// ==== rtl/jdi_sync.sv ====
// Purpose: two flip-flop level synchroniser
// Assumes: each bit is a level or a toggle, stable for several cycles
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps
`default_nettype none
module jdi_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  // ----------------------------------------------------------------
  // two stages per bit
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= async;
      stage2_q <= stage1_q;
    end
  end

  assign synced = stage2_q;

endmodule
`default_nettype wire

// ==== rtl/jdi_jtag_debug_interface.sv ====
// Purpose: serial debug port with test access port and CPU registers
// Assumes: tester keeps the test clock well below the CPU clock
// Notes:   test clock logic resets on trstN; CPU logic resets on rst, except the data register
`timescale 1ns/1ps
`default_nettype none
module jdi_jtag_debug_interface (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     tck,
  input  wire logic                     trstN,
  input  wire logic                     tms,
  input  wire logic                     tdi,
  output logic                          tdo,
  output logic                          tdoOeN,
  input  wire jdi_pkg::jdi_cpu_req_type cpuReq,
  output logic                          cpuAck,
  output logic [31:0]                   cpuRdata,
  output logic                          irqRequest,
  output logic                          debugResetReq
);

  // ----------------------------------------------------------------
  // test clock domain state
  // ----------------------------------------------------------------
  jdi_pkg::jdi_tap_type tapState_q;
  jdi_pkg::jdi_tap_type tapState_d;
  logic [31:0]          irShift_q;
  logic [31:0]          irShift_d;
  logic [31:0]          drShift_q;
  logic [31:0]          drShift_d;
  logic [15:0]          command_q;
  logic [15:0]          command_d;
  logic                 updToggle_q;
  logic                 updToggle_d;
  logic                 irqToggle_q;
  logic                 irqToggle_d;
  logic                 inReset_q;
  logic                 inReset_d;
  logic                 resetAssert_q;
  logic                 resetAssert_d;
  logic                 irqFlagTck;
  logic                 tdo_q;
  logic                 tdoOeN_q;
  logic                 tdo_d;
  logic                 tdoOeN_d;

  // ----------------------------------------------------------------
  // CPU clock domain state
  // ----------------------------------------------------------------
  jdi_pkg::jdi_cross_type crossTck;
  jdi_pkg::jdi_cross_type crossCpu;
  logic                   updSeen_q;
  logic                   updSeen_d;
  logic                   irqSeen_q;
  logic                   irqSeen_d;
  logic [15:0]            cmdMirror_q;
  logic [15:0]            cmdMirror_d;
  logic                   irqFlag_q;
  logic                   irqFlag_d;
  logic                   ack_q;
  logic                   ack_d;
  logic [31:0]            rdata_q;
  logic [31:0]            rdata_d;
  logic [15:0]            dataHigh_q;
  logic [15:0]            dataHigh_d;
  logic [15:0]            dataLow_q;
  logic [15:0]            dataLow_d;
  logic [2:0]             warm_q;
  logic [2:0]             warm_d;
  logic                   updEvent;
  logic                   irqEvent;
  logic                   cpuRead;
  logic                   cpuWrite;

  // ----------------------------------------------------------------
  // test access port state machine
  // ----------------------------------------------------------------
  // next state from tms, five ones from any state reach reset
  always_comb begin
    tapState_d = tapState_q;
    case (tapState_q)
      jdi_pkg::TAP_RESET:      tapState_d = tms ? jdi_pkg::TAP_RESET : jdi_pkg::TAP_IDLE;
      jdi_pkg::TAP_IDLE:       tapState_d = tms ? jdi_pkg::TAP_SEL_DR : jdi_pkg::TAP_IDLE;
      jdi_pkg::TAP_SEL_DR:     tapState_d = tms ? jdi_pkg::TAP_SEL_IR : jdi_pkg::TAP_CAPTURE_DR;
      jdi_pkg::TAP_CAPTURE_DR: tapState_d = tms ? jdi_pkg::TAP_EXIT1_DR : jdi_pkg::TAP_SHIFT_DR;
      jdi_pkg::TAP_SHIFT_DR:   tapState_d = tms ? jdi_pkg::TAP_EXIT1_DR : jdi_pkg::TAP_SHIFT_DR;
      jdi_pkg::TAP_EXIT1_DR:   tapState_d = tms ? jdi_pkg::TAP_UPDATE_DR : jdi_pkg::TAP_PAUSE_DR;
      jdi_pkg::TAP_PAUSE_DR:   tapState_d = tms ? jdi_pkg::TAP_EXIT2_DR : jdi_pkg::TAP_PAUSE_DR;
      jdi_pkg::TAP_EXIT2_DR:   tapState_d = tms ? jdi_pkg::TAP_UPDATE_DR : jdi_pkg::TAP_SHIFT_DR;
      jdi_pkg::TAP_UPDATE_DR:  tapState_d = tms ? jdi_pkg::TAP_SEL_DR : jdi_pkg::TAP_IDLE;
      jdi_pkg::TAP_SEL_IR:     tapState_d = tms ? jdi_pkg::TAP_RESET : jdi_pkg::TAP_CAPTURE_IR;
      jdi_pkg::TAP_CAPTURE_IR: tapState_d = tms ? jdi_pkg::TAP_EXIT1_IR : jdi_pkg::TAP_SHIFT_IR;
      jdi_pkg::TAP_SHIFT_IR:   tapState_d = tms ? jdi_pkg::TAP_EXIT1_IR : jdi_pkg::TAP_SHIFT_IR;
      jdi_pkg::TAP_EXIT1_IR:   tapState_d = tms ? jdi_pkg::TAP_UPDATE_IR : jdi_pkg::TAP_PAUSE_IR;
      jdi_pkg::TAP_PAUSE_IR:   tapState_d = tms ? jdi_pkg::TAP_EXIT2_IR : jdi_pkg::TAP_PAUSE_IR;
      jdi_pkg::TAP_EXIT2_IR:   tapState_d = tms ? jdi_pkg::TAP_UPDATE_IR : jdi_pkg::TAP_SHIFT_IR;
      jdi_pkg::TAP_UPDATE_IR:  tapState_d = tms ? jdi_pkg::TAP_SEL_DR : jdi_pkg::TAP_IDLE;
      default:                 tapState_d = jdi_pkg::TAP_RESET;
    endcase
  end

  // ----------------------------------------------------------------
  // shift paths, command update and event toggles
  // ----------------------------------------------------------------
  // all shift, capture and update actions happen on the rising test clock
  always_comb begin
    irShift_d     = irShift_q;
    drShift_d     = drShift_q;
    command_d     = command_q;
    updToggle_d   = updToggle_q;
    irqToggle_d   = irqToggle_q;
    resetAssert_d = resetAssert_q;
    inReset_d     = (tapState_d == jdi_pkg::TAP_RESET);
    case (tapState_q)
      jdi_pkg::TAP_RESET: begin
        command_d     = jdi_pkg::COMMAND_RESET;
        resetAssert_d = 1'b0;
      end
      jdi_pkg::TAP_CAPTURE_IR: begin
        irShift_d = jdi_pkg::COMMAND_SERIAL_RD;
      end
      jdi_pkg::TAP_SHIFT_IR: begin
        irShift_d = {tdi, irShift_q[31:1]};
      end
      jdi_pkg::TAP_UPDATE_IR: begin
        // reserved low byte always reads as ones
        command_d   = {irShift_q[31:24], jdi_pkg::CMD_LOW_FILL};
        updToggle_d = ~updToggle_q;
        if (irShift_q[31:29] == jdi_pkg::CMD_INTERRUPT) begin
          irqToggle_d = ~irqToggle_q;
        end
        if (irShift_q[31:28] == jdi_pkg::CMD_RESET_ASSERT) begin
          resetAssert_d = 1'b1;
        end
        if (irShift_q[31:28] == jdi_pkg::CMD_RESET_NEGATE) begin
          resetAssert_d = 1'b0;
        end
      end
      jdi_pkg::TAP_CAPTURE_DR: begin
        if (command_q[15:13] == jdi_pkg::CMD_INTERRUPT) begin
          // upper half zero, lower half the source register
          drShift_d = {31'h00000000, irqFlagTck};
        end else begin
          drShift_d = 32'h00000000;
        end
      end
      jdi_pkg::TAP_SHIFT_DR: begin
        if (command_q[15:13] == jdi_pkg::CMD_INTERRUPT) begin
          drShift_d = {tdi, drShift_q[31:1]};
        end else begin
          drShift_d = {drShift_q[31:1], tdi};
        end
      end
      default: drShift_d = drShift_q;
    endcase
  end

  // ----------------------------------------------------------------
  // test clock registers, held at their reset values while trstN is low
  // ----------------------------------------------------------------
  always_ff @(posedge tck or negedge trstN) begin
    if (!trstN) begin
      tapState_q    <= jdi_pkg::TAP_RESET;
      irShift_q     <= 32'h00000000;
      drShift_q     <= 32'h00000000;
      command_q     <= jdi_pkg::COMMAND_RESET;
      updToggle_q   <= 1'b0;
      irqToggle_q   <= 1'b0;
      inReset_q     <= 1'b1;
      resetAssert_q <= 1'b0;
    end else begin
      tapState_q    <= tapState_d;
      irShift_q     <= irShift_d;
      drShift_q     <= drShift_d;
      command_q     <= command_d;
      updToggle_q   <= updToggle_d;
      irqToggle_q   <= irqToggle_d;
      inReset_q     <= inReset_d;
      resetAssert_q <= resetAssert_d;
    end
  end

  // ----------------------------------------------------------------
  // serial output, launched on the falling test clock
  // ----------------------------------------------------------------
  // bypass and unused commands shift through the one-bit bypass cell
  always_comb begin
    tdo_d    = 1'b1;
    tdoOeN_d = 1'b1;
    if (tapState_q == jdi_pkg::TAP_SHIFT_IR) begin
      tdo_d    = irShift_q[0];
      tdoOeN_d = 1'b0;
    end else if (tapState_q == jdi_pkg::TAP_SHIFT_DR) begin
      tdo_d    = drShift_q[0];
      tdoOeN_d = 1'b0;
    end
  end

  always_ff @(negedge tck or negedge trstN) begin
    if (!trstN) begin
      tdo_q    <= 1'b1;
      tdoOeN_q <= 1'b1;
    end else begin
      tdo_q    <= tdo_d;
      tdoOeN_q <= tdoOeN_d;
    end
  end

  assign tdo    = tdo_q;
  assign tdoOeN = tdoOeN_q;

  // ----------------------------------------------------------------
  // crossing into the CPU clock domain
  // ----------------------------------------------------------------
  assign crossTck.updToggle   = updToggle_q;
  assign crossTck.irqToggle   = irqToggle_q;
  assign crossTck.inReset     = inReset_q | ~trstN;
  assign crossTck.resetAssert = resetAssert_q;

  jdi_sync #(
    .WIDTH (4)
  ) u_to_cpu (
    .clock  (clock),
    .rst    (rst),
    .async  (crossTck),
    .synced (crossCpu)
  );

  // pending flag back into the test clock domain for serial reads
  jdi_sync #(
    .WIDTH (1)
  ) u_to_tck (
    .clock  (tck),
    .rst    (~trstN),
    .async  (irqFlag_q),
    .synced (irqFlagTck)
  );

  // ----------------------------------------------------------------
  // CPU side decode
  // ----------------------------------------------------------------
  assign updEvent = crossCpu.updToggle ^ updSeen_q;
  // toggles drop to zero under test reset and read zero while the sync refills
  assign irqEvent = (crossCpu.irqToggle ^ irqSeen_q) & warm_q[2] & ~crossCpu.inReset;
  assign cpuRead  = cpuReq.sel & ~cpuReq.wr;
  assign cpuWrite = cpuReq.sel & cpuReq.wr;

  // ----------------------------------------------------------------
  // CPU side control state
  // ----------------------------------------------------------------
  // command mirror, pending flag and bus answer
  always_comb begin
    updSeen_d   = crossCpu.updToggle;
    irqSeen_d   = crossCpu.irqToggle;
    warm_d      = {warm_q[1:0], 1'b1};
    cmdMirror_d = cmdMirror_q;
    irqFlag_d   = irqFlag_q;
    ack_d       = cpuReq.sel;
    rdata_d     = rdata_q;
    // command is held stable in the test domain once toggled
    if (crossCpu.inReset) begin
      cmdMirror_d = jdi_pkg::COMMAND_RESET;
    end else if (updEvent) begin
      cmdMirror_d = command_q;
    end
    // cpu may only write a zero, a new set wins over the clear
    if (cpuWrite && (cpuReq.addr == jdi_pkg::DEBUG_IRQ_SOURCE_ADDR) &&
        !cpuReq.wdata[jdi_pkg::IRQ_FLAG_BIT]) begin
      irqFlag_d = 1'b0;
    end
    if (crossCpu.inReset) begin
      irqFlag_d = 1'b0;
    end
    if (irqEvent) begin
      irqFlag_d = 1'b1;
    end
    if (cpuRead) begin
      case (cpuReq.addr)
        jdi_pkg::DEBUG_COMMAND_REG_ADDR: rdata_d = {16'h0000, cmdMirror_q};
        jdi_pkg::DEBUG_DATA_HIGH_ADDR: begin
          if (cpuReq.size32) begin
            rdata_d = {dataHigh_q, dataLow_q};
          end else begin
            rdata_d = {16'h0000, dataHigh_q};
          end
        end
        jdi_pkg::DEBUG_DATA_LOW_ADDR:   rdata_d = {16'h0000, dataLow_q};
        jdi_pkg::DEBUG_IRQ_SOURCE_ADDR: rdata_d = {16'h0000, 15'h0000, irqFlag_q};
        default:                        rdata_d = 32'h00000000;
      endcase
    end
  end

  // chip reset only, the test reset reaches here through inReset, not as a reset
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      updSeen_q   <= 1'b0;
      irqSeen_q   <= 1'b0;
      warm_q      <= 3'h0;
      cmdMirror_q <= jdi_pkg::COMMAND_RESET;
      irqFlag_q   <= 1'b0;
      ack_q       <= 1'b0;
      rdata_q     <= 32'h00000000;
    end else begin
      updSeen_q   <= updSeen_d;
      irqSeen_q   <= irqSeen_d;
      warm_q      <= warm_d;
      cmdMirror_q <= cmdMirror_d;
      irqFlag_q   <= irqFlag_d;
      ack_q       <= ack_d;
      rdata_q     <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // data register, two halves, no reset
  // ----------------------------------------------------------------
  // a 32-bit write at the high offset fills both halves
  always_comb begin
    dataHigh_d = dataHigh_q;
    dataLow_d  = dataLow_q;
    if (cpuWrite && (cpuReq.addr == jdi_pkg::DEBUG_DATA_HIGH_ADDR)) begin
      if (cpuReq.size32) begin
        dataHigh_d = cpuReq.wdata[31:16];
        dataLow_d  = cpuReq.wdata[15:0];
      end else begin
        dataHigh_d = cpuReq.wdata[15:0];
      end
    end
    if (cpuWrite && (cpuReq.addr == jdi_pkg::DEBUG_DATA_LOW_ADDR)) begin
      dataLow_d = cpuReq.wdata[15:0];
    end
  end

  always_ff @(posedge clock) begin
    dataHigh_q <= dataHigh_d;
    dataLow_q  <= dataLow_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign cpuAck        = ack_q;
  assign cpuRdata      = rdata_q;
  assign irqRequest    = irqFlag_q;
  assign debugResetReq = crossCpu.resetAssert;

endmodule
`default_nettype wire

// ==== verif/jdi_asserts.sv ====
// Purpose: concurrent checks on the debug port pins and CPU bus
// Assumes: sees only the top module ports
// Notes:   CPU and pin-level checks run on clock, the five-tms check on tck
`timescale 1ns/1ps
`default_nettype none
module jdi_asserts (
  input wire logic                     clock,
  input wire logic                     rst,
  input wire logic                     tck,
  input wire logic                     trstN,
  input wire logic                     tms,
  input wire logic                     tdi,
  input wire logic                     tdo,
  input wire logic                     tdoOeN,
  input wire jdi_pkg::jdi_cpu_req_type cpuReq,
  input wire logic                     cpuAck,
  input wire logic [31:0]              cpuRdata,
  input wire logic                     irqRequest,
  input wire logic                     debugResetReq
);
  // ---------------------------------------------------------------
  // decoded CPU requests
  // ---------------------------------------------------------------
  logic rdCmd;
  logic rdNone;
  logic irqWr;
  assign rdCmd = cpuReq.sel && !cpuReq.wr && cpuReq.addr == jdi_pkg::DEBUG_COMMAND_REG_ADDR;
  assign rdNone = cpuReq.sel && !cpuReq.wr && !(cpuReq.addr inside {
    jdi_pkg::DEBUG_COMMAND_REG_ADDR, jdi_pkg::DEBUG_DATA_HIGH_ADDR,
    jdi_pkg::DEBUG_DATA_LOW_ADDR, jdi_pkg::DEBUG_IRQ_SOURCE_ADDR});
  assign irqWr = cpuReq.sel && cpuReq.wr && cpuReq.addr == jdi_pkg::DEBUG_IRQ_SOURCE_ADDR;
  // request answered one cycle later
  property p_ack;
    @(posedge clock) disable iff (rst) cpuReq.sel |=> cpuAck;
  endproperty
  a_ack: assert property (p_ack) else $error("request not acknowledged");
  // command read: zero upper half, low byte all ones
  property p_cmd;
    @(posedge clock) disable iff (rst)
      rdCmd |=> cpuRdata[31:16] == 16'h0000 && cpuRdata[7:0] == jdi_pkg::CMD_LOW_FILL;
  endproperty
  a_cmd: assert property (p_cmd) else $error("bad command readback");
  // unmapped read gives zero
  property p_none;
    @(posedge clock) disable iff (rst) rdNone |=> cpuRdata == 32'h00000000;
  endproperty
  a_none: assert property (p_none) else $error("unmapped read not zero");
  // CPU write of zero clears the flag
  property p_clr;
    @(posedge clock) disable iff (rst) irqWr && !cpuReq.wdata[0] |-> ##[1:2] !irqRequest;
  endproperty
  a_clr: assert property (p_clr) else $error("flag not cleared");
  // CPU write of one leaves a set flag alone
  property p_keep;
    @(posedge clock) disable iff (rst) irqWr && cpuReq.wdata[0] && irqRequest |=> irqRequest;
  endproperty
  a_keep: assert property (p_keep) else $error("flag lost on write of one");
  // test reset clears flag and reset request
  property p_trst;
    @(posedge clock) disable iff (rst) $fell(trstN) |-> ##[1:6] (!irqRequest && !debugResetReq);
  endproperty
  a_trst: assert property (p_trst) else $error("test reset did not clear");
  // serial output parked while test reset is low
  property p_hold;
    @(posedge clock) disable iff (rst) !trstN ##1 !trstN |-> tdoOeN && tdo;
  endproperty
  a_hold: assert property (p_hold) else $error("output active in test reset");
  // five rises with tms high park the port
  property p_tlr;
    @(posedge tck) disable iff (!trstN) tms [*5] |=> tdoOeN;
  endproperty
  a_tlr: assert property (p_tlr) else $error("no reset after five tms high");
  // output enable moves only while tck is low
  property p_edge;
    @(posedge clock) disable iff (rst || !trstN) $changed(tdoOeN) |-> !tck;
  endproperty
  a_edge: assert property (p_edge) else $error("enable moved off tck fall");
endmodule
bind jdi_jtag_debug_interface jdi_asserts chk_u (.clock(clock), .rst(rst), .tck(tck),
  .trstN(trstN), .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOeN(tdoOeN), .cpuReq(cpuReq),
  .cpuAck(cpuAck), .cpuRdata(cpuRdata), .irqRequest(irqRequest),
  .debugResetReq(debugResetReq));
`default_nettype wire

// ==== verif/jdi_tester.sv ====
// Purpose: tester model driving the serial pins of the debug port
// Assumes: tck runs only inside tlr and scans, 160 ns period
// Notes:   tms and tdi rest high like pulled-up lines, but tms rests low after tlr
`timescale 1ns/1ps
`default_nettype none
module jdi_tester (
  output logic     tck,
  output logic     trstN,
  output logic     tms,
  output logic     tdi,
  input wire logic tdo
);
  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // pins at rest, test reset low from power-up
  initial begin
    tck = 1'h0;
    trstN = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end
  // drive the test reset pin
  task automatic trst(input logic v);
    trstN = v;
  endtask
  // one tck period, tdo taken at the rise
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #80 tck = 1'h1;
    o = tdo;
    #80 tck = 1'h0;
  endtask
  // five tms high, then on to idle
  task automatic tlr();
    logic o;
    repeat (5) tick(1'h1, 1'h1, o);
    tick(1'h0, 1'h1, o);
  endtask
  // idle to shift n bits lsb first, back to idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    dout = 32'h00000000;
    #3 tick(1'h1, 1'h1, o);
    if (ir) begin
      tick(1'h1, 1'h1, o);
    end
    tick(1'h0, 1'h1, o);
    tick(1'h0, 1'h1, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o);
      dout[i] = o;
    end
    tick(1'h1, 1'h1, o);
    tick(1'h0, 1'h1, o);
    tms = 1'h1;
    tdi = 1'h1;
  endtask
endmodule
`default_nettype wire

// ==== verif/test_jtag_debug_interface.sv ====
// Purpose: self-checking bench for the serial debug port
// Assumes: tester model drives the serial pins, CPU tasks here
// Notes:   commands ride in the upper byte of the instruction shift
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin \
  n_tests++; \
  if ((got) !== (ex)) begin \
    error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, got); \
  end \
end
module test_jtag_debug_interface;
  localparam logic [7:0] CMDS [4] = '{{jdi_pkg::CMD_INTERRUPT, 5'h00},
    {jdi_pkg::CMD_RESET_ASSERT, 4'h0}, {jdi_pkg::CMD_RESET_NEGATE, 4'h0}, jdi_pkg::CMD_BYPASS};
  jdi_pkg::jdi_cpu_req_type cpuReq;
  logic        clock;
  logic        rst;
  logic        tck;
  logic        trstN;
  logic        tms;
  logic        tdi;
  logic        tdo;
  logic        tdoOeN;
  logic        cpuAck;
  logic [31:0] cpuRdata;
  logic        irqRequest;
  logic        debugResetReq;
  int          error_cnt;
  int          n_tests;
  logic [31:0] rd;
  logic [31:0] so;
  // ---------------------------------------------------------------
  // design, tester and clock
  // ---------------------------------------------------------------
  jdi_jtag_debug_interface dut_u (.clock(clock), .rst(rst), .tck(tck), .trstN(trstN),
    .tms(tms), .tdi(tdi), .tdo(tdo), .tdoOeN(tdoOeN), .cpuReq(cpuReq), .cpuAck(cpuAck),
    .cpuRdata(cpuRdata), .irqRequest(irqRequest), .debugResetReq(debugResetReq));
  jdi_tester tst_u (.tck(tck), .trstN(trstN), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial begin
    clock = 1'h0;
    forever #5 clock = ~clock;
  end
  // one CPU access, one cycle of select
  task automatic cpu(input logic w, input logic s32, input logic [31:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    #1 cpuReq = '{sel: 1'h1, wr: w, size32: s32, addr: a, wdata: d};
    @(posedge clock);
    #1 cpuReq.sel = 1'h0;
    `CHK("cpuAck", 1'h1, cpuAck)
    q = cpuRdata;
  endtask
  // read one register and compare
  task automatic rdc(input logic s32, input logic [31:0] a, input logic [31:0] ex);
    logic [31:0] q;
    cpu(1'h0, s32, a, 32'h00000000, q);
    `CHK("cpuRdata", ex, q)
  endtask
  // verdict and end of run
  task automatic results();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #900000;
    error_cnt++;
    results();
  end
  // main sequence
  initial begin
    rst = 1'h1;
    cpuReq = '0;
    repeat (10) @(posedge clock);
    #1 rst = 1'h0;
    tst_u.trst(1'h1);
    tst_u.tlr();
    rdc(1'h0, jdi_pkg::DEBUG_COMMAND_REG_ADDR, 32'h0000FFFF);
    rdc(1'h0, jdi_pkg::DEBUG_IRQ_SOURCE_ADDR, 32'h00000000);
    rdc(1'h0, 32'hFFF00010, 32'h00000000);
    cpu(1'h1, 1'h0, jdi_pkg::DEBUG_COMMAND_REG_ADDR, 32'h00000000, rd);
    rdc(1'h0, jdi_pkg::DEBUG_COMMAND_REG_ADDR, 32'h0000FFFF);
    cpu(1'h1, 1'h1, jdi_pkg::DEBUG_DATA_HIGH_ADDR, 32'h12345678, rd);
    cpu(1'h1, 1'h0, jdi_pkg::DEBUG_DATA_LOW_ADDR, 32'h0000ABCD, rd);
    rdc(1'h1, jdi_pkg::DEBUG_DATA_HIGH_ADDR, 32'h1234ABCD);
    rdc(1'h0, jdi_pkg::DEBUG_DATA_HIGH_ADDR, 32'h00001234);
    rdc(1'h0, jdi_pkg::DEBUG_DATA_LOW_ADDR, 32'h0000ABCD);
    tst_u.scan(1'h1, 32, 32'hFFFFFFFF, so);
    `CHK("irShift", jdi_pkg::COMMAND_SERIAL_RD, so)
    // every command, flag persists once set
    for (int i = 0; i < 4; i++) begin
      tst_u.scan(1'h1, 32, {CMDS[i], 24'hFFFFFF}, so);
      rdc(1'h0, jdi_pkg::DEBUG_COMMAND_REG_ADDR, {16'h0000, CMDS[i], 8'hFF});
      `CHK("irqRequest", 1'h1, irqRequest)
      `CHK("debugResetReq", i == 1, debugResetReq)
      if (i == 0) begin
        tst_u.scan(1'h0, 32, 32'h00000000, so);
        `CHK("irqShift", 32'h00000001, so)
      end
    end
    tst_u.scan(1'h0, 8, 32'h000000A5, so);
    `CHK("bypassShift", 32'h0000004A, so)
    rdc(1'h0, jdi_pkg::DEBUG_IRQ_SOURCE_ADDR, 32'h00000001);
    cpu(1'h1, 1'h0, jdi_pkg::DEBUG_IRQ_SOURCE_ADDR, 32'h00000001, rd);
    `CHK("irqRequest", 1'h1, irqRequest)
    cpu(1'h1, 1'h0, jdi_pkg::DEBUG_IRQ_SOURCE_ADDR, 32'h00000000, rd);
    @(posedge clock);
    #1 `CHK("irqRequest", 1'h0, irqRequest)
    // five tms high, then test reset pin
    for (int k = 0; k < 2; k++) begin
      tst_u.scan(1'h1, 32, {CMDS[0], 24'hFFFFFF}, so);
      tst_u.scan(1'h1, 32, {CMDS[1], 24'hFFFFFF}, so);
      if (k == 0) begin
        tst_u.tlr();
      end else begin
        tst_u.trst(1'h0);
      end
      repeat (8) @(posedge clock);
      rdc(1'h0, jdi_pkg::DEBUG_COMMAND_REG_ADDR, 32'h0000FFFF);
      `CHK("irqRequest", 1'h0, irqRequest)
      `CHK("debugResetReq", 1'h0, debugResetReq)
      `CHK("tdoOeN", 1'h1, tdoOeN)
      tst_u.trst(1'h1);
      tst_u.tlr();
    end
    // chip reset in mid-run with the flag set, data kept
    tst_u.scan(1'h1, 32, {CMDS[0], 24'hFFFFFF}, so);
    `CHK("irqRequest", 1'h1, irqRequest)
    @(posedge clock);
    #1 rst = 1'h1;
    repeat (3) @(posedge clock);
    #1 rst = 1'h0;
    rdc(1'h1, jdi_pkg::DEBUG_DATA_HIGH_ADDR, 32'h1234ABCD);
    `CHK("debugResetReq", 1'h0, debugResetReq)
    repeat (4) @(posedge clock);
    #1 `CHK("irqRequest", 1'h0, irqRequest)
    results();
  end
endmodule
`default_nettype wire
